// file: rtl/cpd_consts.svh
// constants for the complementary dead-band pwm block
`ifndef CPD_CONSTS_SVH
`define CPD_CONSTS_SVH

// register byte offsets
`define CPD_ADDR_CTRL 8'h00
`define CPD_ADDR_PERIOD 8'h04
`define CPD_ADDR_DUTY 8'h08
`define CPD_ADDR_PHASE 8'h0C
`define CPD_ADDR_RED 8'h10
`define CPD_ADDR_FED 8'h14
`define CPD_ADDR_STATUS 8'h18
`define CPD_ADDR_COMPARE 8'h1C

// control field positions
`define CPD_CTRL_MASTER_BIT 0
`define CPD_CTRL_RUN_BIT 1

// reset values
`define CPD_RST_CTRL 2'h1
`define CPD_RST_PERIOD 24'h000000
`define CPD_RST_DUTY 24'h000000
`define CPD_RST_DELAY 10'h000

// fixed-point shapes
`define CPD_PERIOD_FRAC 14
`define CPD_DUTY_FRAC 24
`define CPD_CNT_W 10
`define CPD_DB_W 10

`endif

// file: rtl/cpd_pkg.sv
// types for the complementary dead-band pwm block
package cpd_pkg;

    typedef logic [9:0] cpd_cnt_t;

    // classic wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } cpd_wb_req_s;

    // classic wishbone answer from this slave
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } cpd_wb_rsp_s;

    // pwm pin pair
    typedef struct packed {
        logic chan_a;
        logic chan_b;
    } cpd_pwm_s;

    typedef enum logic [1:0] {
        CPD_DB_IDLE,
        CPD_DB_WAIT_A,
        CPD_DB_WAIT_B
    } cpd_db_e;

endpackage

// file: rtl/cpd_pwm.sv
// complementary pwm pair with dead band, up-count time base and sync
// Summary of operation
// - period is unsigned Q14; software loads it before the duty update.
// - Q24 duty times current period gives integer compare value for channel A.
// - period sets the highest count before the counter restarts.
// - counter counts up only; dead band yields complementary outputs.
// - channel B is the complement of the A source; both channels delayed.
// - falling delay holds off the rising edge of channel B.
// - channel A active high; channel B complementary, also active high.
// - mode 1 is master ignoring sync; mode 0 is slave obeying sync.
// - in slave mode a sync pulse loads the phase offset into the counter.
// - both delay registers are writable while the pwm runs.
`timescale 1ns/1ps
`include "cpd_consts.svh"

module cpd_pwm
    import cpd_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire cpd_wb_req_s wb_req,
    output cpd_wb_rsp_s wb_rsp,
    input wire logic sync_input,
    output cpd_pwm_s pwm_out
);

    // software state
    logic [1:0] ctrl_ff;
    logic [23:0] period_register_ff;
    logic [23:0] duty_ff;
    cpd_cnt_t phase_offset_register_ff;
    logic [`CPD_DB_W-1:0] rising_delay_register_ff;
    logic [`CPD_DB_W-1:0] falling_delay_register_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    // time base and waveform state
    cpd_cnt_t counter_ff;
    cpd_cnt_t compare_a_value_ff;
    logic source_a_ff;
    logic [`CPD_DB_W-1:0] delay_cnt_ff;
    logic chan_a_ff;
    logic chan_b_ff;
    logic sync_meta_ff;
    logic sync_sync_ff;
    logic sync_prev_ff;
    cpd_db_e db_state_ff;

    logic wb_hit;
    logic wb_write;
    logic sync_pulse;
    logic master_mode;
    logic run_en;
    cpd_cnt_t period_count;
    logic [47:0] duty_product;
    cpd_cnt_t nxt_compare;
    cpd_db_e nxt_db_state;

    assign wb_hit = wb_req.cyc & wb_req.stb & ~ack_ff;
    assign wb_write = wb_hit & wb_req.we;
    assign master_mode = ctrl_ff[`CPD_CTRL_MASTER_BIT];
    assign run_en = ctrl_ff[`CPD_CTRL_RUN_BIT];

    // Q14 to integer: drop the fraction, the counter is whole cycles
    assign period_count = period_register_ff[`CPD_PERIOD_FRAC +: `CPD_CNT_W];

    // duty scaling: Q24 times integer period, keep integer part
    assign duty_product = {24'h000000, duty_ff} * {38'h0000000000, period_count};
    assign nxt_compare = duty_product[`CPD_DUTY_FRAC +: `CPD_CNT_W];

    // sync gating: rising edge of the synchronised pin, from the second and third stages; the first stage only feeds the second
    assign sync_pulse = sync_sync_ff & ~sync_prev_ff & ~master_mode;

    // synchroniser for the outside sync pin
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync_meta_ff <= 1'b0;
            sync_sync_ff <= 1'b0;
            sync_prev_ff <= 1'b0;
        end else if (clk_en) begin
            sync_meta_ff <= sync_input;
            sync_sync_ff <= sync_meta_ff;
            sync_prev_ff <= sync_sync_ff;
        end
    end

    // control, period, duty and phase registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_ff <= `CPD_RST_CTRL;
            period_register_ff <= `CPD_RST_PERIOD;
            duty_ff <= `CPD_RST_DUTY;
            phase_offset_register_ff <= '0;
        end else if (clk_en && wb_write) begin
            unique case (wb_req.adr)
                `CPD_ADDR_CTRL: ctrl_ff <= wb_req.dat[1:0];
                // programmed value is already count minus one
                `CPD_ADDR_PERIOD: period_register_ff <= wb_req.dat[23:0];
                `CPD_ADDR_DUTY: duty_ff <= wb_req.dat[23:0];
                `CPD_ADDR_PHASE: phase_offset_register_ff <= wb_req.dat[`CPD_CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // live delay writes: taken on any cycle, used at once, also by an edge wait already running
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rising_delay_register_ff <= `CPD_RST_DELAY;
            falling_delay_register_ff <= `CPD_RST_DELAY;
        end else if (clk_en && wb_write) begin
            if (wb_req.adr == `CPD_ADDR_RED) begin
                rising_delay_register_ff <= wb_req.dat[`CPD_DB_W-1:0];
            end
            if (wb_req.adr == `CPD_ADDR_FED) begin
                falling_delay_register_ff <= wb_req.dat[`CPD_DB_W-1:0];
            end
        end
    end

    // bus answer: one wait state, ack drops the cycle after it rose
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else if (clk_en) begin
            ack_ff <= wb_hit;
            rdata_ff <= 32'h00000000;
            if (wb_hit && !wb_req.we) begin
                unique case (wb_req.adr)
                    `CPD_ADDR_CTRL: rdata_ff <= {30'h00000000, ctrl_ff};
                    `CPD_ADDR_PERIOD: rdata_ff <= {8'h00, period_register_ff};
                    `CPD_ADDR_DUTY: rdata_ff <= {8'h00, duty_ff};
                    `CPD_ADDR_PHASE: rdata_ff <= {22'h000000, phase_offset_register_ff};
                    `CPD_ADDR_RED: rdata_ff <= {22'h000000, rising_delay_register_ff};
                    `CPD_ADDR_FED: rdata_ff <= {22'h000000, falling_delay_register_ff};
                    // status: count in the low ten bits, then source, channel A, channel B
                    `CPD_ADDR_STATUS: rdata_ff <= {19'h00000, chan_b_ff, chan_a_ff, source_a_ff, counter_ff};
                    `CPD_ADDR_COMPARE: rdata_ff <= {22'h000000, compare_a_value_ff};
                    default: rdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            counter_ff <= '0;
        end else if (clk_en) begin
            if (sync_pulse) begin
                counter_ff <= phase_offset_register_ff;
            end else if (!run_en) begin
                counter_ff <= '0;
            end else if (counter_ff >= period_count) begin
                counter_ff <= '0;
            end else begin
                counter_ff <= counter_ff + 10'h001;
            end
        end
    end

    // compare shadow: reloaded at count zero so an edge never tears mid cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            compare_a_value_ff <= '0;
        end else if (clk_en && (counter_ff == '0)) begin
            compare_a_value_ff <= nxt_compare;
        end
    end

    // source waveform: compare wins over zero so compare zero stays low
    always_ff @(posedge core_clk) begin
        if (reset) begin
            source_a_ff <= 1'b0;
        end else if (clk_en) begin
            if (!run_en || counter_ff == compare_a_value_ff) begin
                source_a_ff <= 1'b0;
            end else if (counter_ff == '0) begin
                source_a_ff <= 1'b1;
            end
        end
    end

    // dead-band sequencer: both outputs go low at once, then one rises late
    always_comb begin
        nxt_db_state = db_state_ff;
        unique case (db_state_ff)
            CPD_DB_IDLE: begin
                if (source_a_ff && !chan_a_ff) begin
                    nxt_db_state = CPD_DB_WAIT_A;
                end else if (!source_a_ff && !chan_b_ff) begin
                    nxt_db_state = CPD_DB_WAIT_B;
                end
            end
            CPD_DB_WAIT_A: begin
                if (!source_a_ff) begin
                    nxt_db_state = CPD_DB_IDLE;
                end else if (delay_cnt_ff >= rising_delay_register_ff) begin
                    nxt_db_state = CPD_DB_IDLE;
                end
            end
            CPD_DB_WAIT_B: begin
                if (source_a_ff) begin
                    nxt_db_state = CPD_DB_IDLE;
                end else if (delay_cnt_ff >= falling_delay_register_ff) begin
                    nxt_db_state = CPD_DB_IDLE;
                end
            end
        endcase
    end

    // dead-band state and delay count
    always_ff @(posedge core_clk) begin
        if (reset) begin
            db_state_ff <= CPD_DB_IDLE;
            delay_cnt_ff <= '0;
        end else if (clk_en) begin
            db_state_ff <= nxt_db_state;
            if (nxt_db_state == CPD_DB_IDLE || nxt_db_state != db_state_ff) begin
                delay_cnt_ff <= 10'h001;
            end else begin
                delay_cnt_ff <= delay_cnt_ff + 10'h001;
            end
        end
    end

    // output pair: A is the delayed source, B is its delayed complement
    always_ff @(posedge core_clk) begin
        if (reset) begin
            chan_a_ff <= 1'b0;
            chan_b_ff <= 1'b0;
        end else if (clk_en) begin
            // complement: any source change drops the active side at once
            if (!source_a_ff) begin
                chan_a_ff <= 1'b0;
            end else if (db_state_ff == CPD_DB_WAIT_A && delay_cnt_ff >= rising_delay_register_ff) begin
                chan_a_ff <= 1'b1;
            end
            if (source_a_ff) begin
                chan_b_ff <= 1'b0;
            end else if (db_state_ff == CPD_DB_WAIT_B && delay_cnt_ff >= falling_delay_register_ff) begin
                chan_b_ff <= 1'b1;
            end
        end
    end

    assign wb_rsp.ack = ack_ff;
    assign wb_rsp.dat = rdata_ff;
    assign pwm_out.chan_a = chan_a_ff;
    assign pwm_out.chan_b = chan_b_ff;

endmodule // cpd_pwm

// file: dv/cpd_pwm_properties.sv
// bus and pin pair checks for the pwm block
`timescale 1ns/1ps
module cpd_pwm_chk
    import cpd_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire cpd_wb_req_s wb_req,
    input wire cpd_wb_rsp_s wb_rsp,
    input wire logic sync_input,
    input wire cpd_pwm_s pwm_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // request taken only when no answer is pending
    sequence s_taken;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack && clk_en;
    endsequence
    sequence s_a_off;
        !pwm_out.chan_a;
    endsequence
    property p_ack_next;
        s_taken |=> wb_rsp.ack;
    endproperty
    property p_ack_pulse;
        wb_rsp.ack && clk_en |=> !wb_rsp.ack;
    endproperty
    property p_ack_cause;
        $rose(wb_rsp.ack) |-> $past(wb_req.cyc && wb_req.stb);
    endproperty
    property p_dat_idle;
        !wb_rsp.ack |-> wb_rsp.dat == 32'h0;
    endproperty
    property p_no_overlap;
        !(pwm_out.chan_a && pwm_out.chan_b);
    endproperty
    property p_b_gap;
        $rose(pwm_out.chan_b) |-> $past(!pwm_out.chan_a);
    endproperty
    property p_a_gap;
        $rose(pwm_out.chan_a) |-> $past(!pwm_out.chan_b);
    endproperty
    property p_reset_quiet;
        $fell(reset) |-> s_a_off ##0 (!pwm_out.chan_b && !wb_rsp.ack);
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    a_no_overlap: assert property (p_no_overlap) else $error("both channels on");
    a_b_gap: assert property (p_b_gap) else $error("b rose without dead time");
    a_a_gap: assert property (p_a_gap) else $error("a rose without dead time");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active at reset");
endmodule // cpd_pwm_chk
bind cpd_pwm cpd_pwm_chk cpd_pwm_chk_i(.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .sync_input(sync_input), .pwm_out(pwm_out));

// file: dv/cpd_fw_model.sv
// firmware side: classic wishbone master doing single accesses
`timescale 1ns/1ps
`include "cpd_consts.svh"
module cpd_fw_model
    import cpd_pkg::*;
(
    input wire logic core_clk,
    output cpd_wb_req_s wb_req,
    input wire cpd_wb_rsp_s wb_rsp
);
    initial wb_req = '0;
    // hold the request until ack is sampled; the caller's timeout ends a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge core_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
        do @(posedge core_clk); while (wb_rsp.ack !== 1'b1);
        q = wb_rsp.dat;
        wb_req <= '0;
    endtask
    // period written as count minus one, before the duty
    task automatic set_timing(input int cnt, input logic [23:0] duty);
        logic [31:0] q;
        xfer(1'b1, `CPD_ADDR_PERIOD, 32'(cnt - 1) << 14, q);
        xfer(1'b1, `CPD_ADDR_DUTY, {8'h00, duty}, q);
    endtask
endmodule // cpd_fw_model

// file: dv/complementary_pwm_deadband_test.sv
// self-checking bench for the complementary pwm block
`timescale 1ns/1ps
`include "cpd_consts.svh"
module complementary_pwm_deadband_test;
    import cpd_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic sync_input = 1'b0;
    cpd_wb_req_s wb_req;
    cpd_wb_rsp_s wb_rsp;
    cpd_pwm_s pwm_out;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] q;
    cpd_pwm cpd_pwm_i(.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .sync_input(sync_input), .pwm_out(pwm_out));
    cpd_fw_model cpd_fw_model_i(.core_clk(core_clk), .wb_req(wb_req), .wb_rsp(wb_rsp));
    always #4 core_clk = ~core_clk;
    // hang guard, sized well above the short test list
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        cpd_fw_model_i.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        cpd_fw_model_i.xfer(1'b1, a, d, t);
    endtask
    // count high cycles of each channel over one full period
    task automatic measure(input int n, output int ha, output int hb);
        ha = 0;
        hb = 0;
        repeat (n) begin
            @(posedge core_clk);
            ha += int'(pwm_out.chan_a === 1'b1);
            hb += int'(pwm_out.chan_b === 1'b1);
        end
    endtask
    task automatic t_regs();
        rd(`CPD_ADDR_CTRL);
        chk(q, 32'h1);
        rd(8'hFC);
        chk(q, 32'h0);
        $display("regs done");
    endtask
    task automatic t_wave();
        int ha;
        int hb;
        cpd_fw_model_i.set_timing(10, 24'h800000);
        wr(`CPD_ADDR_RED, 32'h2);
        wr(`CPD_ADDR_FED, 32'h1);
        wr(`CPD_ADDR_CTRL, 32'h3);
        repeat (30) @(posedge core_clk);
        rd(`CPD_ADDR_COMPARE);
        chk(q, 32'h4);
        rd(`CPD_ADDR_RED);
        chk(q, 32'h2);
        measure(10, ha, hb);
        chk(32'(ha), 32'h2);
        chk(32'(hb), 32'h5);
        wr(`CPD_ADDR_DUTY, 32'h0);
        repeat (25) @(posedge core_clk);
        measure(10, ha, hb);
        chk(32'(ha), 32'h0);
        chk(32'(hb), 32'hA);
        $display("wave done");
    endtask
    // sync only moves the counter when the block is a slave
    task automatic t_sync();
        int mx = 0;
        wr(`CPD_ADDR_CTRL, 32'h0);
        cpd_fw_model_i.set_timing(1000, 24'h400000);
        wr(`CPD_ADDR_PHASE, 32'd500);
        wr(`CPD_ADDR_CTRL, 32'h3);
        @(posedge core_clk) sync_input <= 1'b1;
        repeat (8) @(posedge core_clk);
        sync_input <= 1'b0;
        rd(`CPD_ADDR_STATUS);
        chk(32'(q[9:0] < 10'd100), 32'h1);
        wr(`CPD_ADDR_CTRL, 32'h2);
        @(posedge core_clk) sync_input <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd(`CPD_ADDR_STATUS);
        chk(32'(q[9:0] >= 10'd500 && q[9:0] < 10'd530), 32'h1);
        sync_input <= 1'b0;
        cpd_fw_model_i.set_timing(12, 24'h400000);
        // five-cycle stride is coprime to the 12-cycle period, so every count gets sampled
        repeat (30) begin
            rd(`CPD_ADDR_STATUS);
            if (int'(q[9:0]) > mx) mx = int'(q[9:0]);
            repeat (2) @(posedge core_clk);
        end
        chk(32'(mx), 32'd11);
        $display("sync done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        t_regs();
        t_wave();
        t_sync();
        complete_run();
    end
endmodule // complementary_pwm_deadband_test
